// ### shared/sdc_defines.svh
// Register offsets, field positions and timing constants of the SDRAM controller.
// Behaviour
// - Column read/write command, A10 low, no auto-precharge.
// - Row activate with bank and row valid.
// - Precharge all banks with A10 high.
// - Mode loads use bank LL or LH.
// - Auto-refresh: CS, RAS, CAS low, WE high.
// - Refresh issued autonomously at programmed interval.
// - Self-refresh: refresh code while CKE falls.
// - Power-down: CKE falls with chip select high.
// - Selected idle cycle is a no-operation.
// - Inhibit holds CKE high, chip selects high.
// - Burst terminate ends the burst early.
// - Memory clock equals the system clock.
// - Inverted memory clock is also provided.
// - CKE low moves memory to low power.
// - Byte masks active-high on writes, ignored reads.
// - Banks from bus bits 20 and 21.
// - 16-bit port uses upper half-word.
// - Two chip selects, up to 256 MB.
// - CAS latency 2 or 3 (2.5 rounds up).
// - Address bit 10 qualifies commands.
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// Register offsets.
`define SDC_RA_W        12
`define SDC_OFS_CS0     12'h034
`define SDC_OFS_CS1     12'h038
`define SDC_OFS_CTRL    12'h104
`define SDC_OFS_MODE    12'h108
`define SDC_OFS_STAT    12'h10c
// Control register fields.
`define SDC_CTL_REF_EN  0
`define SDC_CTL_CL3     1
`define SDC_CTL_DDR     2
`define SDC_CTL_PORT16  3
`define SDC_CTL_SELF    4
`define SDC_CTL_NAP     5
`define SDC_CTL_MRS_GO  6
`define SDC_CTL_RI_LSB  16
`define SDC_CTL_RI_MSB  31
// Chip-select and mode register fields.
`define SDC_CS_BASE_LSB 20
`define SDC_CS_SIZE_MSB 4
`define SDC_CS_SIZE_MIN 5'h13
`define SDC_CS_SIZE_MAX 5'h1b
`define SDC_MODE_EXT    16
`define SDC_MODE_MSB    12
// Bus address map (conventional numbering).
`define SDC_BA_HI       11
`define SDC_BA_LO       10
`define SDC_COL_MSB     9
`define SDC_COL_LSB     2
`define SDC_ROW_MSB     24
`define SDC_ROW_LSB     12
`define SDC_HALF_MSB    31
`define SDC_HALF_LSB    16
`define SDC_A10         10
// Command codes as {ras_n, cas_n, we_n}.
`define SDC_C_NOP       3'h7
`define SDC_C_READ      3'h5
`define SDC_C_WRITE     3'h4
`define SDC_C_ACT       3'h3
`define SDC_C_BST       3'h6
`define SDC_C_PREALL    3'h2
`define SDC_C_MRS       3'h0
`define SDC_C_REF       3'h1
`define SDC_BA_LL       2'h0
`define SDC_BA_LH       2'h1
// Timing in ns and the clock rate in MHz.
`define SDC_CLK_MHZ     25
`define SDC_CLK_MAX_MHZ 132
`define SDC_T_RCD_NS    20
`define SDC_T_RP_NS     20
`define SDC_T_RFC_NS    70
`define SDC_T_MRD_NS    15
`define SDC_T_XSR_NS    120
`define SDC_CYC(ns)     ((((ns) * `SDC_CLK_MHZ) + 999) / 1000)
`define SDC_CL_SHORT    8'h02
`define SDC_CL_LONG     8'h03
`define SDC_SYNC_LAT    8'h02

`endif

// ### shared/sdc_pkg.sv
// Types shared by the SDRAM controller and its bench.
package sdc_pkg;

    // Memory command pins, registered as one word.
    typedef struct packed {
        logic        cke;
        logic [1:0]  cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] ma;
    } sdc_cmd_s;

    // One system bus access request.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } sdc_req_s;

    // Controller states, one-hot.
    typedef enum logic [11:0] {
        ST_IDLE = 12'h001,
        ST_ACT  = 12'h002,
        ST_RCD  = 12'h004,
        ST_COL  = 12'h008,
        ST_BST  = 12'h010,
        ST_CAS  = 12'h020,
        ST_PRE  = 12'h040,
        ST_RP   = 12'h080,
        ST_REF  = 12'h100,
        ST_MRS  = 12'h200,
        ST_WAIT = 12'h400,
        ST_LOW  = 12'h800
    } sdc_state_e;

    // Where to go once all banks are closed.
    typedef enum logic [1:0] {
        AF_IDLE = 2'h0,
        AF_REF  = 2'h1,
        AF_MRS  = 2'h2,
        AF_LOW  = 2'h3
    } sdc_after_e;

endpackage

// ### hw/sdc_ctrl.sv
// Two-chip-select SDR/DDR SDRAM command controller with register port.
//
// Our own choice: the address-and-strobe port.
`include "sdc_defines.svh"

module sdc_ctrl
    import sdc_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Register port.
    input  wire logic [`SDC_RA_W-1:0]  reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    // System bus access side.
    input  wire sdc_req_s              req,
    output logic                       req_ready,
    output logic                       rsp_done,
    output logic                       rsp_err,
    output logic      [31:0]           rsp_rdata,
    // Memory pins.
    output logic                       mem_clk,
    output logic                       mem_clk_n,
    output sdc_cmd_s                   mem_cmd,
    output logic      [3:0]            mem_dqm,
    input  wire logic [31:0]           dq_in,
    output logic      [31:0]           dq_out,
    output logic                       dq_oe,
    input  wire logic [3:0]            dqs_in,
    output logic      [3:0]            dqs_out,
    output logic                       dqs_oe
);

    // ****************************************************************
    // Constants and helpers
    // ****************************************************************

    localparam logic [7:0] L_RCD = 8'(`SDC_CYC(`SDC_T_RCD_NS) - 1);
    localparam logic [7:0] L_RP  = 8'(`SDC_CYC(`SDC_T_RP_NS) - 1);
    localparam logic [7:0] L_RFC = 8'(`SDC_CYC(`SDC_T_RFC_NS) - 1);
    localparam logic [7:0] L_MRD = 8'(`SDC_CYC(`SDC_T_MRD_NS) - 1);
    localparam logic [7:0] L_XSR = 8'(`SDC_CYC(`SDC_T_XSR_NS) - 1);

    // Builds one command word.
    function automatic sdc_cmd_s mk(input logic cke, input logic [1:0] cs_n,
                                    input logic [2:0] code, input logic [1:0] ba,
                                    input logic [12:0] ma);
        sdc_cmd_s c;
        c.cke   = cke;
        c.cs_n  = cs_n;
        c.ras_n = code[2];
        c.cas_n = code[1];
        c.we_n  = code[0];
        c.ba    = ba;
        c.ma    = ma;
        return c;
    endfunction

    // Region hit: size code s covers 2^(s+1) bytes, base bits above must match.
    function automatic logic cs_hit(input logic [31:0] cfg, input logic [31:0] a);
        logic [4:0] sz;
        logic       ok;
        sz = cfg[`SDC_CS_SIZE_MSB:0];
        ok = (sz >= `SDC_CS_SIZE_MIN) && (sz <= `SDC_CS_SIZE_MAX);
        for (int i = `SDC_CS_BASE_LSB; i < 32; i++)
        begin
            if ((i > int'(sz)) && (cfg[i] != a[i]))
                ok = 1'b0;
        end
        return ok;
    endfunction

    // ****************************************************************
    // Registers and wires
    // ****************************************************************

    logic [31:0] ctrl_reg, cs0_reg, cs1_reg, mode_reg, rdata_reg;
    logic        mrs_pend_reg, mrs_pend_next, ref_due_reg, ref_due_next;
    logic [15:0] ref_cnt_reg, ref_cnt_next;
    sdc_state_e  state_reg, state_next;
    sdc_after_e  after_reg, after_next;
    logic [7:0]  wait_reg, wait_next;
    logic        low_self_reg, low_self_next;
    sdc_req_s    acc_reg;
    logic        cs1_sel_reg;
    sdc_cmd_s    cmd_reg, cmd_next;
    logic [31:0] dq_s1_reg, dq_s2_reg, dq_out_reg, rd_reg, rd_next;
    logic [3:0]  dqm_reg, dqm_next;
    logic        dq_oe_reg, dqs_oe_reg, done_reg, err_reg;

    // Register decode.
    wire         wr_cs0   = reg_wr && (reg_addr == `SDC_OFS_CS0);
    wire         wr_cs1   = reg_wr && (reg_addr == `SDC_OFS_CS1);
    wire         wr_ctrl  = reg_wr && (reg_addr == `SDC_OFS_CTRL);
    wire         wr_mode  = reg_wr && (reg_addr == `SDC_OFS_MODE);
    wire         mrs_go   = wr_ctrl && reg_wdata[`SDC_CTL_MRS_GO];
    wire [31:0]  stat     = {26'h0, cmd_reg.cke, low_self_reg, ref_due_reg,
                             mrs_pend_reg, state_reg != ST_IDLE, cs1_sel_reg};
    wire [31:0]  rd_sel   = (reg_addr == `SDC_OFS_CS0)  ? cs0_reg  :
                            (reg_addr == `SDC_OFS_CS1)  ? cs1_reg  :
                            (reg_addr == `SDC_OFS_CTRL) ? ctrl_reg :
                            (reg_addr == `SDC_OFS_MODE) ? mode_reg :
                            (reg_addr == `SDC_OFS_STAT) ? stat : 32'h0000_0000;

    // Control fields.
    wire [15:0]  ri       = ctrl_reg[`SDC_CTL_RI_MSB:`SDC_CTL_RI_LSB];
    wire         port16   = ctrl_reg[`SDC_CTL_PORT16];
    wire         lp_req   = ctrl_reg[`SDC_CTL_SELF] | ctrl_reg[`SDC_CTL_NAP];
    wire [7:0]   cl       = ctrl_reg[`SDC_CTL_CL3] ? `SDC_CL_LONG : `SDC_CL_SHORT;
    wire         ref_on   = ctrl_reg[`SDC_CTL_REF_EN] && (ri != 16'h0000);

    // Request acceptance and region decode.
    wire         hit0     = cs_hit(cs0_reg, req.addr);
    wire         hit1     = cs_hit(cs1_reg, req.addr);
    wire         idle_free = (state_reg == ST_IDLE) && !mrs_pend_reg
                             && !ref_due_reg && !lp_req;
    wire         take     = req.valid && idle_free;
    wire         wait_le1 = wait_reg <= 8'h01;
    wire [1:0]   cs_sel_n = cs1_sel_reg ? 2'h1 : 2'h2;
    wire         is_wr    = acc_reg.write;

    // Access address split; banks from bus bits 20:21 counted from the MSB.
    wire [1:0]   bank     = {acc_reg.addr[`SDC_BA_HI], acc_reg.addr[`SDC_BA_LO]};
    wire [12:0]  row      = acc_reg.addr[`SDC_ROW_MSB:`SDC_ROW_LSB];
    wire [12:0]  col      = {5'h00, acc_reg.addr[`SDC_COL_MSB:`SDC_COL_LSB]};
    wire [12:0]  a10_only = 13'h0001 << `SDC_A10;
    wire         rd_last  = (state_reg == ST_CAS) && wait_le1;

    // Refresh timer: due flag is set by the timer, set wins over clear.
    wire         ref_tick = ref_on && (ref_cnt_reg >= 16'(ri - 16'h0001));
    assign ref_cnt_next  = (!ref_on || ref_tick) ? 16'h0000 : 16'(ref_cnt_reg + 16'h0001);
    assign ref_due_next  = ref_tick | (ref_due_reg & (state_reg != ST_REF));
    assign mrs_pend_next = mrs_go | (mrs_pend_reg & (state_reg != ST_MRS));

    // Write data and masks; a 16-bit port carries the upper half-word.
    wire [31:0]  wdat     = port16 ? {16'h0000, acc_reg.wdata[`SDC_HALF_MSB:`SDC_HALF_LSB]}
                                   : acc_reg.wdata;
    wire [3:0]   wmask    = port16 ? {2'h3, ~acc_reg.be[3:2]} : ~acc_reg.be;
    wire         wr_beat  = (state_reg == ST_COL) && is_wr;
    assign dqm_next = wr_beat ? wmask : 4'h0;
    assign rd_next  = port16 ? {dq_s2_reg[15:0], 16'h0000} : dq_s2_reg;

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Next state, command word and wait count.
    always_comb
    begin
        state_next    = state_reg;
        after_next    = after_reg;
        low_self_next = low_self_reg;
        wait_next     = (wait_reg != 8'h00) ? 8'(wait_reg - 8'h01) : 8'h00;
        cmd_next      = mk(1'b1, 2'h3, `SDC_C_NOP, 2'h0, 13'h0000);
        unique case (state_reg)
            ST_IDLE:
            begin
                if (mrs_pend_reg)
                begin
                    state_next = ST_PRE;
                    after_next = AF_MRS;
                end
                else if (ref_due_reg)
                begin
                    state_next = ST_PRE;
                    after_next = AF_REF;
                end
                else if (lp_req)
                begin
                    state_next = ST_PRE;
                    after_next = AF_LOW;
                end
                else if (take && (hit0 || hit1))
                    state_next = ST_ACT;
            end
            ST_ACT:
            begin
                cmd_next   = mk(1'b1, cs_sel_n, `SDC_C_ACT, bank, row);
                wait_next  = L_RCD;
                state_next = ST_RCD;
            end
            ST_RCD:
            begin
                cmd_next = mk(1'b1, cs_sel_n, `SDC_C_NOP, 2'h0, 13'h0000);
                if (wait_le1)
                    state_next = ST_COL;
            end
            ST_COL:
            begin
                cmd_next   = mk(1'b1, cs_sel_n, is_wr ? `SDC_C_WRITE : `SDC_C_READ,
                                bank, col);
                state_next = ST_BST;
            end
            ST_BST:
            begin
                cmd_next   = mk(1'b1, cs_sel_n, `SDC_C_BST, 2'h0, 13'h0000);
                wait_next  = 8'(cl + `SDC_SYNC_LAT);
                state_next = ST_CAS;
            end
            ST_CAS:
            begin
                cmd_next = mk(1'b1, cs_sel_n, `SDC_C_NOP, 2'h0, 13'h0000);
                if (wait_le1)
                begin
                    state_next = ST_PRE;
                    after_next = AF_IDLE;
                end
            end
            ST_PRE:
            begin
                cmd_next   = mk(1'b1, 2'h0, `SDC_C_PREALL, 2'h0, a10_only);
                wait_next  = L_RP;
                state_next = ST_RP;
            end
            ST_RP:
            begin
                if (wait_le1)
                begin
                    unique case (after_reg)
                        AF_IDLE: state_next = ST_IDLE;
                        AF_REF:  state_next = ST_REF;
                        AF_MRS:  state_next = ST_MRS;
                        AF_LOW:  state_next = ST_LOW;
                    endcase
                    low_self_next = ctrl_reg[`SDC_CTL_SELF];
                end
            end
            ST_REF:
            begin
                cmd_next   = mk(1'b1, 2'h0, `SDC_C_REF, 2'h0, 13'h0000);
                wait_next  = L_RFC;
                state_next = ST_WAIT;
            end
            ST_MRS:
            begin
                cmd_next   = mk(1'b1, 2'h0, `SDC_C_MRS,
                                mode_reg[`SDC_MODE_EXT] ? `SDC_BA_LH : `SDC_BA_LL,
                                mode_reg[`SDC_MODE_MSB:0]);
                wait_next  = L_MRD;
                state_next = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (wait_le1)
                    state_next = ST_IDLE;
            end
            ST_LOW:
            begin
                if (cmd_reg.cke)
                    cmd_next = low_self_reg ? mk(1'b0, 2'h0, `SDC_C_REF, 2'h0, 13'h0000)
                                            : mk(1'b0, 2'h3, `SDC_C_NOP, 2'h0, 13'h0000);
                else if (!lp_req || (!low_self_reg && ref_due_reg))
                begin
                    wait_next  = L_XSR;
                    state_next = ST_WAIT;
                end
                else
                    cmd_next = mk(1'b0, 2'h3, `SDC_C_NOP, 2'h0, 13'h0000);
            end
        endcase
    end

    // Sequencer state and command pins.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg    <= ST_IDLE;
            after_reg    <= AF_IDLE;
            wait_reg     <= 8'h00;
            low_self_reg <= 1'b0;
            cmd_reg      <= mk(1'b1, 2'h3, `SDC_C_NOP, 2'h0, 13'h0000);
        end
        else
        begin
            state_reg    <= state_next;
            after_reg    <= after_next;
            wait_reg     <= wait_next;
            low_self_reg <= low_self_next;
            cmd_reg      <= cmd_next;
        end
    end

    // Access capture, data path and answers.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_reg     <= '0;
            cs1_sel_reg <= 1'b0;
            dq_out_reg  <= 32'h0000_0000;
            dq_oe_reg   <= 1'b0;
            dqs_oe_reg  <= 1'b0;
            dqm_reg     <= 4'h0;
            rd_reg      <= 32'h0000_0000;
            done_reg    <= 1'b0;
            err_reg     <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                acc_reg     <= req;
                cs1_sel_reg <= !hit0;
            end
            dq_out_reg <= wdat;
            dq_oe_reg  <= wr_beat;
            dqs_oe_reg <= wr_beat && ctrl_reg[`SDC_CTL_DDR];
            dqm_reg    <= dqm_next;
            if (rd_last && !is_wr)
                rd_reg <= rd_next;
            done_reg   <= rd_last || (take && !hit0 && !hit1);
            err_reg    <= take && !hit0 && !hit1;
        end
    end

    // Data input synchroniser: the first stage feeds only the second.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dq_s1_reg <= 32'h0000_0000;
            dq_s2_reg <= 32'h0000_0000;
        end
        else
        begin
            dq_s1_reg <= dq_in;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // Software registers, refresh timer and pending flags.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_reg     <= 32'h0000_0000;
            cs0_reg      <= 32'h0000_0000;
            cs1_reg      <= 32'h0000_0000;
            mode_reg     <= 32'h0000_0000;
            rdata_reg    <= 32'h0000_0000;
            mrs_pend_reg <= 1'b0;
            ref_due_reg  <= 1'b0;
            ref_cnt_reg  <= 16'h0000;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= reg_wdata & ~(32'h1 << `SDC_CTL_MRS_GO);
            if (wr_cs0)
                cs0_reg <= reg_wdata & 32'hfff0_001f;
            if (wr_cs1)
                cs1_reg <= reg_wdata & 32'hfff0_001f;
            if (wr_mode)
                mode_reg <= reg_wdata & 32'h0001_1fff;
            rdata_reg    <= reg_rd ? rd_sel : 32'h0000_0000;
            mrs_pend_reg <= mrs_pend_next;
            ref_due_reg  <= ref_due_next;
            ref_cnt_reg  <= ref_cnt_next;
        end
    end

    // Outputs; the memory clock is the system clock and its inverse.
    assign mem_clk   = clk;
    assign mem_clk_n = ~clk;
    assign mem_cmd   = cmd_reg;
    assign mem_dqm   = dqm_reg;
    assign dq_out    = dq_out_reg;
    assign dq_oe     = dq_oe_reg;
    assign dqs_out   = 4'h0;
    assign dqs_oe    = dqs_oe_reg;
    assign req_ready = idle_free;
    assign rsp_done  = done_reg;
    assign rsp_err   = err_reg;
    assign rsp_rdata = rd_reg;
    assign reg_rdata = rdata_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Tracks whether any row was opened since the last precharge.
    logic open_reg;
    wire  [2:0] pin_code = {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
    always_ff @(posedge clk)
    begin
        if (rst)
            open_reg <= 1'b0;
        else if (pin_code == `SDC_C_ACT && mem_cmd.cs_n != 2'h3)
            open_reg <= 1'b1;
        else if (pin_code == `SDC_C_PREALL && mem_cmd.cs_n == 2'h0)
            open_reg <= 1'b0;
    end

    a_clk_limit: assert property (`SDC_CLK_MHZ <= `SDC_CLK_MAX_MHZ)
        else $error("clock above memory limit");
    a_col_shape: assert property ($past(state_reg == ST_COL) |->
        mem_cmd.cs_n == cs_sel_n && mem_cmd.ras_n && !mem_cmd.cas_n
        && !mem_cmd.ma[`SDC_A10] && mem_cmd.we_n == !is_wr)
        else $error("bad column command");
    a_act_shape: assert property ($past(state_reg == ST_ACT) |->
        mem_cmd.cke && pin_code == `SDC_C_ACT && mem_cmd.ma == row)
        else $error("bad activate");
    a_preall_a10: assert property ($past(state_reg == ST_PRE) |->
        pin_code == `SDC_C_PREALL && mem_cmd.ma[`SDC_A10] && mem_cmd.cs_n == 2'h0)
        else $error("bad precharge all");
    a_mrs_bank: assert property ($past(state_reg == ST_MRS) |->
        pin_code == `SDC_C_MRS && mem_cmd.ba == ($past(mode_reg[`SDC_MODE_EXT])
        ? `SDC_BA_LH : `SDC_BA_LL))
        else $error("bad mode load bank");
    a_ref_closed: assert property (mem_cmd.cke && mem_cmd.cs_n == 2'h0
        && (pin_code == `SDC_C_REF || pin_code == `SDC_C_MRS) |-> !open_reg)
        else $error("refresh or mode load with open row");
    a_self_entry: assert property ($fell(mem_cmd.cke) && low_self_reg |->
        mem_cmd.cs_n == 2'h0 && pin_code == `SDC_C_REF)
        else $error("bad self-refresh entry");
    a_nap_entry: assert property ($fell(mem_cmd.cke) && !low_self_reg |->
        mem_cmd.cs_n == 2'h3)
        else $error("bad power-down entry");
    a_idle_quiet: assert property ($past(state_reg == ST_IDLE, 2) &&
        $past(state_reg == ST_IDLE) |-> mem_cmd.cke && mem_cmd.cs_n == 2'h3)
        else $error("idle without inhibit");
    a_read_mask: assert property (mem_cmd.cs_n != 2'h3
        && pin_code == `SDC_C_READ |-> mem_dqm == 4'h0 && !dq_oe)
        else $error("mask or drive during read");
    a_refresh_auto: assert property (ref_due_reg && state_reg == ST_IDLE
        && !mrs_pend_reg |-> ##[1:16] (pin_code == `SDC_C_REF && mem_cmd.cs_n == 2'h0))
        else $error("refresh not issued");

    c_read: cover property (rsp_done && !rsp_err && !acc_reg.write);
    c_write: cover property (rsp_done && !rsp_err && acc_reg.write);
    c_refresh: cover property (pin_code == `SDC_C_REF && mem_cmd.cke);
    c_self: cover property ($fell(mem_cmd.cke) && low_self_reg);

endmodule // sdc_ctrl

// ### testbench/sdc_mem_model.sv
// Behavioural one-word SDRAM model that answers the controller's memory pins.
`include "sdc_defines.svh"

module sdc_mem_model
    import sdc_pkg::*;
(
    // Clock and memory pins.
    input  wire logic        clk,
    input  wire sdc_cmd_s    mem_cmd,
    input  wire logic [3:0]  mem_dqm,
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe,
    output logic      [31:0] dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] word = 32'h0;
    logic        rd_q = 1'b0;
    wire  [2:0]  code = {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
    wire         sel  = mem_cmd.cke && mem_cmd.cs_n != 2'h3;
    initial dq_in = 32'h5a5a_a5a5;
    // Read data lands two cycles after the read; otherwise the bus toggles.
    always @(posedge clk)
    begin
        rd_q  <= sel && code == `SDC_C_READ;
        dq_in <= rd_q ? word : ~dq_in;
        if (sel && code == `SDC_C_WRITE && dq_oe)
            for (int i = 0; i < 4; i++)
                if (!mem_dqm[i])
                    word[8*i+:8] <= dq_out[8*i+:8];
    end
endmodule // sdc_mem_model

// ### testbench/tb_top.sv
// Self-checking bench for the SDRAM command controller.
`include "sdc_defines.svh"

module tb_top
    import sdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rsp_done, rsp_err, req_ready;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rsp_rdata, dq_in, dq_out;
    logic [3:0] mem_dqm;
    logic dq_oe, mem_clk, mem_clk_n, err_q;
    sdc_req_s req = '0;
    sdc_cmd_s mem_cmd;
    logic [2:0] last_c = 0;
    logic [16:0] act_seen = 0;
    logic [14:0] mrs_seen = 0;
    int n_fail = 0, tests_run = 0, n_ref = 0, bad = 0, cyc = 0;
    wire [2:0] c = {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
    sdc_ctrl u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req),
        .req_ready(req_ready), .rsp_done(rsp_done), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
        .mem_clk(mem_clk), .mem_clk_n(mem_clk_n), .mem_cmd(mem_cmd), .mem_dqm(mem_dqm),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(4'h0), .dqs_out(), .dqs_oe());
    sdc_mem_model u_mem (.clk(clk), .mem_cmd(mem_cmd), .mem_dqm(mem_dqm), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in));
    always #20 clk = ~clk;
    // Watch selected commands, remembering fields and catching misordered refreshes.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            results();
        end
        if (!rst && mem_cmd.cs_n != 2'h3 && c != `SDC_C_NOP)
        begin
            if (c == `SDC_C_REF && mem_cmd.cke && last_c != `SDC_C_PREALL) bad++;
            if (c == `SDC_C_REF && mem_cmd.cke) n_ref++;
            if (c == `SDC_C_MRS) mrs_seen <= {mem_cmd.ba, mem_cmd.ma};
            if (c == `SDC_C_ACT) act_seen <= {mem_cmd.cs_n, mem_cmd.ba, mem_cmd.ma};
            if (c[2:1] == 2'h2 && mem_cmd.ma[10]) bad++;
            if (c == `SDC_C_PREALL && !mem_cmd.ma[10]) bad++;
            last_c <= c;
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (e !== g)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 0;
        #1 chk("reg", e, reg_rdata);
    endtask
    // Hold the request until taken, then wait a bounded time for completion.
    task automatic acc(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] be);
        @(posedge clk) req <= '{1'b1, w, a, d, be};
        do @(posedge clk); while (!req_ready);
        req.valid <= 0;
        for (int n = 0; n < 40 && rsp_done !== 1'b1; n++) @(posedge clk);
        chk("done", 1, rsp_done);
        err_q = rsp_err;
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        rd(`SDC_OFS_CTRL, 0);
        wr(12'h0fc, 32'hffff_ffff);
        rd(12'h0fc, 0);
        wr(`SDC_OFS_CS0, 32'h0000_ff13);
        rd(`SDC_OFS_CS0, 32'h13);
        wr(`SDC_OFS_CS1, 32'h0010_0013);
        acc(1, 32'h4, 32'h1122_3344, 4'h5);
        acc(0, 32'h4, 0, 4'hf);
        chk("masked", 32'h0022_0044, rsp_rdata);
        acc(0, 32'h0010_0c04, 0, 4'hf);
        chk("act", {2'h1, 2'h3, 13'h100}, act_seen);
        chk("cs1 rd", 32'h0022_0044, rsp_rdata);
        acc(0, 32'h8000_0000, 0, 4'hf);
        chk("miss", 1, err_q);
        wr(`SDC_OFS_CTRL, 32'h8);
        acc(1, 32'h4, 32'haabb_ccdd, 4'hf);
        acc(0, 32'h4, 0, 4'hf);
        chk("half", 32'haabb_0000, rsp_rdata);
        #1 chk("clk", {~clk, clk}, {mem_clk_n, mem_clk});
        wr(`SDC_OFS_MODE, 32'h0001_0123);
        wr(`SDC_OFS_CTRL, 32'h40);
        repeat (40) @(posedge clk);
        chk("mode", {2'h1, 13'h123}, mrs_seen);
        wr(`SDC_OFS_CTRL, 32'h0040_0001);
        repeat (300) @(posedge clk);
        chk("refresh", 1, n_ref >= 3);
        wr(`SDC_OFS_CTRL, 32'h10);
        repeat (40) @(posedge clk);
        chk("self", 0, mem_cmd.cke);
        wr(`SDC_OFS_CTRL, 0);
        repeat (40) @(posedge clk);
        chk("wake", 1, mem_cmd.cke);
        wr(`SDC_OFS_CTRL, 32'h20);
        repeat (40) @(posedge clk);
        chk("nap", 3'h3, {mem_cmd.cke, mem_cmd.cs_n});
        chk("cmds", 0, bad);
        results();
    end
endmodule // tb_top
